// ### encslv_core.sv
// Slave-side command interpreter of a fieldbus rotary encoder.
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Diagnostic reply is short or long.
// - Cyclic reply: position word, then optional speed.
// - Top bit set loads remaining bits as position.
// - Address change only from class 2 master.
// - Switch code 126 selects stored address.
// - Stored address defaults to 125.
// - Switch 0 to 125 is the node address.
// - Switches sampled once at power-up.
// - Stored address changes only via address service.
// - Parameters by parameter telegram, preset by exchange.
// - After power-on, wait in parameter mode.
// - Configuration telegram fixes cyclic byte counts.
// - Normal mode: preset in, position/velocity out.
// - Diagnostics after power-on and on request.
// - Parameter byte ten holds the operating bits.
// - Class 1: position, direction, preset.
// - Class 2 adds selectable diagnostic length.
// - Velocity class adds velocity transmission.
// - Diagnostic bit 0 short, 1 long.
// - Exchange bit 0 position, 1 position plus velocity.
// - Code sequence picks counting direction.
// - Class 2 bit 0 means class 1 operation.
module encslv_core
  import encslv_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic [6:0] ADDR_SWITCH,
  input wire logic ENC_STEP,
  input wire logic ENC_CW,
  input wire tlg_t TLG,
  output rpl_t RPL,
  input wire logic RPL_READY,
  output logic [6:0] NODE_ADDR,
  output logic NODE_ADDR_VALID,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA
);

  // Pick one byte, most significant first, out of a 32-bit word.
  function automatic logic [7:0] word_byte(input logic [31:0] w, input logic [1:0] sel);
    logic [7:0] b;
    b = 8'h00;
    unique case (sel)
      2'b00: b = w[31:24];
      2'b01: b = w[23:16];
      2'b10: b = w[15:8];
      2'b11: b = w[7:0];
    endcase
    return b;
  endfunction

  // Operating mode and committed parameter byte.
  mode_t mode;
  logic [7:0] op_byte;
  logic [7:0] op_pending;      // Byte ten captured while the frame is still arriving.
  logic op_seen;               // The running parameter frame has reached byte ten.
  logic prm_err;               // Last parameter frame was too short.
  logic cfg_err;               // Last configuration did not match the exchange type.
  logic [5:0] cfg_len;         // Input byte count fixed by the configuration.

  // Address state.
  logic [6:0] stored_addr;     // Survives only as long as this flop; no real non-volatile store here.
  logic sw_taken;
  logic from_store;
  logic switch_bad;

  // Receive framing.
  tlg_kind_t rx_kind;
  logic [5:0] rx_cnt;
  logic [23:0] out_shift;      // First three bytes of the cyclic output word.

  // Position and speed.
  logic [31:0] position;
  logic [31:0] speed;
  logic preset_armed;          // Cleared after a preset, set again once the top bit drops.

  // Reply engine.
  rpl_kind_t rpl_kind;
  logic [5:0] rpl_idx;
  logic [5:0] rpl_len;
  logic [31:0] pos_snap;
  logic [31:0] spd_snap;
  logic rpl_valid;
  logic rpl_last;
  logic [7:0] rpl_data;
  logic diag_pending;
  logic overrun;

  // Effective class and options; class 1 forces short diagnostics and position only.
  wire class2_on = op_byte[OP_CLASS2];
  wire diag_long = class2_on & op_byte[OP_DIAG_LONG];
  wire vel_on = class2_on & op_byte[OP_EXCH_VEL];
  wire code_ccw = op_byte[OP_CODE_SEQ];

  // Current byte index and frame events.
  wire [5:0] cur_idx = TLG.first ? 6'h00 : rx_cnt;
  wire tlg_kind_t cur_kind = TLG.first ? TLG.kind : rx_kind;
  wire frame_end = TLG.valid & TLG.last;
  wire prm_end = frame_end & (cur_kind == KIND_PRM);
  wire cfg_end = frame_end & (cur_kind == KIND_CFG);
  wire dx_end = frame_end & (cur_kind == KIND_DXCH);
  wire diag_req = frame_end & (cur_kind == KIND_DIAG);
  wire adr_end = frame_end & (cur_kind == KIND_SETADR);
  wire op_here = TLG.valid & (cur_kind == KIND_PRM) & (cur_idx == PRM_OP_BYTE);

  // Parameter frame: the operating byte is byte ten; bytes below are network bytes.
  wire prm_ok = op_here | op_seen;
  wire [7:0] prm_value = op_here ? TLG.data : op_pending;

  // Configuration: only the length matching the exchange type is accepted.
  wire [5:0] cfg_want = vel_on ? POS_VEL_BYTES : WORD_BYTES;
  wire cfg_ok = (cfg_end && cur_idx == 6'h00) ? (TLG.data[5:0] == cfg_want) : 1'b0;

  // Cyclic output word, complete only when exactly four bytes arrived.
  wire [31:0] dx_word = {out_shift, TLG.data};
  wire dx_full = dx_end & (cur_idx == WORD_BYTES - 6'h01) & (mode == MODE_DXCH);
  wire preset_hit = dx_full & dx_word[PRESET_BIT] & preset_armed;
  wire preset_drop = dx_full & ~dx_word[PRESET_BIT];

  // Address service: class 2 master only, one byte, in range.
  wire adr_ok = adr_end & TLG.class2 & (cur_idx == 6'h00) & (TLG.data[6:0] <= NODE_MAX);

  // Reply start requests; data wins over a waiting diagnostic.
  wire rpl_busy = (rpl_kind != RPL_NONE);
  wire start_data = dx_full & ~rpl_busy;
  wire start_diag = (diag_pending | diag_req) & ~rpl_busy & ~dx_full;
  wire lost_req = (dx_full | diag_req) & rpl_busy;
  wire rpl_take = rpl_valid & RPL_READY;
  wire rpl_done = rpl_take & (rpl_idx == rpl_len - 6'h01);
  wire [5:0] rpl_next_idx = rpl_idx + 6'h01;

  // Diagnostic header bytes; bytes four to seven carry the position, the rest read as zero.
  wire status_t status = '{
    spare: 7'h00, op_byte: op_byte, node_addr: NODE_ADDR, switch_bad: switch_bad,
    from_store: from_store, overrun: overrun, cfg_err: cfg_err, prm_err: prm_err,
    diag_pending: diag_pending, busy: rpl_busy, mode: mode, vel_on: vel_on};

  // Reply byte selection for a given kind and index.
  function automatic logic [7:0] reply_byte(input rpl_kind_t k, input logic [5:0] i,
                                            input logic [31:0] p, input logic [31:0] s,
                                            input logic [31:0] st);
    logic [7:0] b;
    b = 8'h00;
    if (k == RPL_DATA) begin
      b = (i < WORD_BYTES) ? word_byte(p, i[1:0]) : word_byte(s, i[1:0]);
    end else if (i < WORD_BYTES) begin
      b = word_byte(st, i[1:0]);
    end else if (i < POS_VEL_BYTES) begin
      b = word_byte(p, i[1:0]);
    end
    return b;
  endfunction

  wire [31:0] status_word = status;
  wire [31:0] pos_now = preset_hit ? {1'b0, dx_word[30:0]} : position;
  wire [5:0] data_len = (vel_on && cfg_len == POS_VEL_BYTES) ? POS_VEL_BYTES : WORD_BYTES;
  wire [5:0] diag_len = diag_long ? DIAG_LONG_LEN : DIAG_SHORT_LEN;
  wire [7:0] first_data = reply_byte(RPL_DATA, 6'h00, pos_now, speed, status_word);
  wire [7:0] first_diag = reply_byte(RPL_DIAG, 6'h00, position, speed, status_word);
  wire [7:0] next_byte = reply_byte(rpl_kind, rpl_next_idx, pos_snap, spd_snap, status_word);

  // Position counting direction: code sequence 0 counts up clockwise.
  wire count_up = ENC_CW ^ code_ccw;

  // Register read multiplexer; unmapped offsets read as zero.
  wire [31:0] next_rdata =
    (REG_ADDR == REG_STATUS) ? status_word :
    (REG_ADDR == REG_POSITION) ? position :
    (REG_ADDR == REG_SPEED) ? speed :
    (REG_ADDR == REG_STORED_ADDR) ? {25'h0000000, stored_addr} :
    (REG_ADDR == REG_CFG_LEN) ? {26'h0000000, cfg_len} : 32'h00000000;
  wire status_read = REG_RD & (REG_ADDR == REG_STATUS);

  // Node address is chosen once, on the first edge after reset release.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      sw_taken <= 1'b0;
      NODE_ADDR <= 7'h00;
      from_store <= 1'b0;
      switch_bad <= 1'b0;
    end else if (!sw_taken) begin
      sw_taken <= 1'b1;
      if (ADDR_SWITCH <= NODE_MAX) begin
        NODE_ADDR <= ADDR_SWITCH;
      end else if (ADDR_SWITCH == NODE_USE_STORED) begin
        NODE_ADDR <= stored_addr;
        from_store <= 1'b1;
      end else begin
        // Code 127 is not a valid node; fall back to the top legal address and flag it.
        NODE_ADDR <= NODE_MAX;
        switch_bad <= 1'b1;
      end
    end
  end
  assign NODE_ADDR_VALID = sw_taken;

  // Stored address: only the address service writes it, never the switches.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      stored_addr <= STORED_DEFAULT;
    end else if (adr_ok) begin
      stored_addr <= TLG.data[6:0];
    end
  end

  // Receive framing: byte counter, kind and partial output word.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_cnt <= 6'h00;
      rx_kind <= KIND_PRM;
      out_shift <= 24'h000000;
    end else if (TLG.valid) begin
      rx_kind <= cur_kind;
      rx_cnt <= (cur_idx == IDX_MAX) ? IDX_MAX : cur_idx + 6'h01;
      if (cur_kind == KIND_DXCH && cur_idx < WORD_BYTES) begin
        out_shift <= {out_shift[15:0], TLG.data};
      end
    end
  end

  // Mode sequencer: parameters, then configuration, then cyclic exchange.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      mode <= MODE_PRM;
      op_byte <= OP_RESET;
      op_pending <= OP_RESET;
      op_seen <= 1'b0;
      prm_err <= 1'b0;
      cfg_err <= 1'b0;
      cfg_len <= WORD_BYTES;
    end else begin
      // A new parameter frame forgets any earlier partial capture.
      if (TLG.valid && TLG.first) begin
        op_seen <= 1'b0;
      end
      if (op_here && !frame_end) begin
        op_pending <= TLG.data;
        op_seen <= 1'b1;
      end
      if (prm_end) begin
        // A short frame leaves the old parameters and keeps waiting for a good one.
        if (prm_ok) begin
          op_byte <= prm_value;
          mode <= MODE_CFG;
          prm_err <= 1'b0;
        end else begin
          mode <= MODE_PRM;
          prm_err <= 1'b1;
        end
      end else if (cfg_end && mode != MODE_PRM) begin
        if (cfg_ok) begin
          cfg_len <= TLG.data[5:0];
          mode <= MODE_DXCH;
          cfg_err <= 1'b0;
        end else begin
          mode <= MODE_CFG;
          cfg_err <= 1'b1;
        end
      end
    end
  end

  // Position counter; a preset wins over a count step in the same cycle.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      position <= 32'h00000000;
      preset_armed <= 1'b1;
    end else begin
      if (preset_hit) begin
        position <= {1'b0, dx_word[30:0]};
        preset_armed <= 1'b0;
      end else if (ENC_STEP) begin
        position <= count_up ? position + 32'h00000001 : position - 32'h00000001;
      end
      // Holding the top bit set does not reload again; only a word with the top bit clear re-arms.
      if (preset_drop) begin
        preset_armed <= 1'b1;
      end
    end
  end

  // Speed word is supplied by local software over the register port.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      speed <= 32'h00000000;
    end else if (REG_WR && REG_ADDR == REG_SPEED) begin
      speed <= REG_WDATA;
    end
  end

  // Sticky flags: a new event in the clearing cycle wins.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      diag_pending <= 1'b1;
      overrun <= 1'b0;
    end else begin
      if (diag_req && rpl_busy) begin
        diag_pending <= 1'b1;
      end else if (start_diag) begin
        diag_pending <= 1'b0;
      end
      if (lost_req) begin
        overrun <= 1'b1;
      end else if (status_read) begin
        overrun <= 1'b0;
      end
    end
  end

  // Reply engine: one byte per accepted handshake, snapshots frozen at the start.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rpl_kind <= RPL_NONE;
      rpl_idx <= 6'h00;
      rpl_len <= WORD_BYTES;
      pos_snap <= 32'h00000000;
      spd_snap <= 32'h00000000;
      rpl_valid <= 1'b0;
      rpl_last <= 1'b0;
      rpl_data <= 8'h00;
    end else if (start_data) begin
      rpl_kind <= RPL_DATA;
      rpl_idx <= 6'h00;
      rpl_len <= data_len;
      pos_snap <= pos_now;
      spd_snap <= speed;
      rpl_valid <= 1'b1;
      rpl_last <= 1'b0;
      rpl_data <= first_data;
    end else if (start_diag) begin
      rpl_kind <= RPL_DIAG;
      rpl_idx <= 6'h00;
      rpl_len <= diag_len;
      pos_snap <= position;
      spd_snap <= speed;
      rpl_valid <= 1'b1;
      rpl_last <= 1'b0;
      rpl_data <= first_diag;
    end else if (rpl_done) begin
      rpl_kind <= RPL_NONE;
      rpl_valid <= 1'b0;
      rpl_last <= 1'b0;
    end else if (rpl_take) begin
      rpl_idx <= rpl_next_idx;
      rpl_data <= next_byte;
      rpl_last <= (rpl_next_idx == rpl_len - 6'h01);
    end
  end

  assign RPL = '{valid: rpl_valid, last: rpl_last, data: rpl_data};

  // Register read data, valid in the cycle after the read strobe only.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_RDATA <= 32'h00000000;
    end else if (REG_RD) begin
      REG_RDATA <= next_rdata;
    end else begin
      REG_RDATA <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// ### encslv_pkg.sv
// Shared constants, enumerations and carrier structs for the encoder fieldbus slave.
package encslv_pkg;

  // Node address limits and the reserved switch code that selects the stored address.
  localparam logic [6:0] NODE_MAX = 7'h7D;
  localparam logic [6:0] NODE_USE_STORED = 7'h7E;
  localparam logic [6:0] STORED_DEFAULT = 7'h7D;

  // Position of the operating byte inside the parameter frame, and its bit layout.
  localparam logic [5:0] PRM_OP_BYTE = 6'h0A;
  localparam int OP_CODE_SEQ = 0;
  localparam int OP_CLASS2 = 1;
  localparam int OP_DIAG_LONG = 6;
  localparam int OP_EXCH_VEL = 7;
  localparam logic [7:0] OP_RESET = 8'h00;

  // Reply lengths in bytes.
  localparam logic [5:0] DIAG_SHORT_LEN = 6'h10;
  localparam logic [5:0] DIAG_LONG_LEN = 6'h3F;
  localparam logic [5:0] WORD_BYTES = 6'h04;
  localparam logic [5:0] POS_VEL_BYTES = 6'h08;
  localparam logic [5:0] IDX_MAX = 6'h3F;

  // Preset control bit of the cyclic output word.
  localparam int PRESET_BIT = 31;

  // Register byte offsets on the local register port.
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_POSITION = 8'h04;
  localparam logic [7:0] REG_SPEED = 8'h08;
  localparam logic [7:0] REG_STORED_ADDR = 8'h0C;
  localparam logic [7:0] REG_CFG_LEN = 8'h10;

  // Kind of telegram delivered by the link layer.
  typedef enum logic [2:0] {
    KIND_PRM = 3'b000,
    KIND_CFG = 3'b001,
    KIND_DXCH = 3'b010,
    KIND_DIAG = 3'b011,
    KIND_SETADR = 3'b100
  } tlg_kind_t;

  // Operating mode of the slave.
  typedef enum logic [1:0] {
    MODE_PRM = 2'b00,
    MODE_CFG = 2'b01,
    MODE_DXCH = 2'b10
  } mode_t;

  // Reply currently being sent.
  typedef enum logic [1:0] {
    RPL_NONE = 2'b00,
    RPL_DIAG = 2'b01,
    RPL_DATA = 2'b10
  } rpl_kind_t;

  // One received telegram byte with its framing.
  typedef struct packed {
    logic valid;
    logic first;
    logic last;
    tlg_kind_t kind;
    logic class2;
    logic [7:0] data;
  } tlg_t;

  // One reply byte towards the link layer.
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } rpl_t;

  // Status register layout, 32 bits.
  typedef struct packed {
    logic [6:0] spare;
    logic [7:0] op_byte;
    logic [6:0] node_addr;
    logic switch_bad;
    logic from_store;
    logic overrun;
    logic cfg_err;
    logic prm_err;
    logic diag_pending;
    logic busy;
    mode_t mode;
    logic vel_on;
  } status_t;

endpackage

// ### encslv_core_assertions.sv
// Port-level concurrent checks for the encoder fieldbus slave.
`timescale 1ns/1ps
`default_nettype none
module encslv_checker
  import encslv_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic [6:0] ADDR_SWITCH,
  input wire logic ENC_STEP,
  input wire logic ENC_CW,
  input wire tlg_t TLG,
  input wire rpl_t RPL,
  input wire logic RPL_READY,
  input wire logic [6:0] NODE_ADDR,
  input wire logic NODE_ADDR_VALID,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA
);
  // Bytes already taken in the reply now under way.
  logic [6:0] taken;
  // The count restarts after the final byte, so each reply is measured alone.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      taken <= 7'h00;
    end else if (RPL.valid && RPL_READY) begin
      taken <= RPL.last ? 7'h00 : taken + 7'h01;
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  // A reply byte handed over to the master.
  sequence s_take;
    RPL.valid && RPL_READY;
  endsequence
  // Final byte of a diagnostic request while the reply path is idle.
  sequence s_diag_req;
    TLG.valid && TLG.last && (TLG.kind == KIND_DIAG) && !RPL.valid;
  endsequence
  AST_NODE_SWITCH: assert property ($rose(NODE_ADDR_VALID) && $past(ADDR_SWITCH) <= NODE_MAX |->
    NODE_ADDR == $past(ADDR_SWITCH)) else $error("node address differs from switch");
  AST_NODE_STORED: assert property ($rose(NODE_ADDR_VALID) && $past(ADDR_SWITCH) > NODE_MAX |->
    NODE_ADDR == 7'h7D) else $error("node address differs from stored default");
  AST_NODE_HOLD: assert property (NODE_ADDR_VALID |=> NODE_ADDR_VALID && $stable(NODE_ADDR))
    else $error("node address changed after power-up");
  AST_POWERON_DIAG: assert property ($rose(NODE_ADDR_VALID) |-> RPL.valid)
    else $error("no diagnostic reply after power-up");
  AST_DIAG_REQ: assert property (s_diag_req |=> RPL.valid) else $error("diagnostic request unanswered");
  AST_RPL_HOLD: assert property (RPL.valid && !RPL_READY |=> RPL.valid && $stable(RPL.data) &&
    $stable(RPL.last)) else $error("reply byte changed before taken");
  AST_RPL_LEN: assert property (s_take ##0 RPL.last |-> taken == 7'h03 || taken == 7'h07 ||
    taken == 7'h0F || taken == 7'h3E) else $error("reply length not 4, 8, 16 or 63");
  AST_LAST_ONCE: assert property (s_take ##0 RPL.last |=> !(RPL.valid && RPL.last))
    else $error("final byte repeated");
  AST_RDATA_IDLE: assert property (!REG_RD |=> REG_RDATA == 32'h00000000)
    else $error("read data outside read answer");
  AST_STORED_WIDTH: assert property (REG_RD && REG_ADDR == REG_STORED_ADDR |=>
    REG_RDATA[31:7] == 25'h0000000) else $error("stored address wider than seven bits");
endmodule
bind encslv_core encslv_checker u_checker (
  .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .ADDR_SWITCH(ADDR_SWITCH), .ENC_STEP(ENC_STEP),
  .ENC_CW(ENC_CW), .TLG(TLG), .RPL(RPL), .RPL_READY(RPL_READY), .NODE_ADDR(NODE_ADDR),
  .NODE_ADDR_VALID(NODE_ADDR_VALID), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA)
);
`default_nettype wire

// ### encslv_master_model.sv
// Behavioural fieldbus master that sends telegrams and collects replies.
`timescale 1ns/1ps
`default_nettype none
module encslv_master_model
  import encslv_pkg::*;
(
  input wire logic CLK_SYS,
  output var tlg_t TLG,
  output var logic RPL_READY,
  input wire rpl_t RPL
);
  // Reply bytes taken, in order.
  logic [7:0] got[$];
  // Index of the byte that carried the final mark.
  int last_at = -1;
  // When set, the master takes only every other cycle.
  logic slow = 1'b0;
  initial begin
    TLG = '0;
    RPL_READY = 1'b1;
  end
  // Collect each byte taken; a slow master pauses to prove the slave holds its byte.
  always @(posedge CLK_SYS) begin
    if (RPL.valid && RPL_READY) begin
      if (RPL.last) begin
        last_at = got.size();
      end
      got.push_back(RPL.data);
    end
    RPL_READY <= slow ? ~RPL_READY : 1'b1;
  end
  // Send one telegram a byte a cycle; the idle data line then shows the inverse value.
  task automatic send(input tlg_kind_t k, input logic c2, input logic [7:0] q[$]);
    for (int i = 0; i < q.size(); i++) begin
      TLG <= '{valid: 1'b1, first: (i == 0), last: (i == q.size() - 1), kind: k, class2: c2, data: q[i]};
      @(posedge CLK_SYS);
    end
    TLG <= '{valid: 1'b0, first: 1'b0, last: 1'b0, kind: k, class2: 1'b0, data: ~q[q.size() - 1]};
    @(posedge CLK_SYS);
  endtask
  // Parameter frame: ten network bytes, then the operating byte.
  task automatic prm(input logic [7:0] op);
    logic [7:0] q[$];
    for (int i = 0; i < 10; i++) begin
      q.push_back(8'h00);
    end
    q.push_back(op);
    send(KIND_PRM, 1'b0, q);
  endtask
  // Cyclic output word, most significant byte first.
  task automatic dx(input logic [31:0] w);
    send(KIND_DXCH, 1'b0, '{w[31:24], w[23:16], w[15:8], w[7:0]});
  endtask
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking testbench for the encoder fieldbus slave.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import encslv_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n;
  logic [6:0] addr_switch;
  logic enc_step;
  logic enc_cw;
  tlg_t tlg;
  rpl_t rpl;
  logic rpl_ready;
  logic [6:0] node_addr;
  logic node_addr_valid;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  int miscompares = 0;
  int checks_done = 0;
  logic [31:0] d;
  status_t st;
  // 25 MHz system clock.
  always #20 clk_sys = ~clk_sys;
  encslv_core u_encslv_core (
    .CLK_SYS(clk_sys), .ARST_N(arst_n), .ADDR_SWITCH(addr_switch), .ENC_STEP(enc_step),
    .ENC_CW(enc_cw), .TLG(tlg), .RPL(rpl), .RPL_READY(rpl_ready), .NODE_ADDR(node_addr),
    .NODE_ADDR_VALID(node_addr_valid), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata)
  );
  encslv_master_model u_master (.CLK_SYS(clk_sys), .TLG(tlg), .RPL_READY(rpl_ready), .RPL(rpl));
  // Print the verdict and stop.
  task automatic wrap_up;
    if (miscompares == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Compare one value with its expectation.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One-cycle register write.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // One-cycle register read; data is taken mid-way through the following cycle.
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    v = reg_rdata;
    @(posedge clk_sys);
  endtask
  // Wait, bounded, until a reply of n bytes has been fully taken.
  task automatic get_reply(input int n);
    int k;
    k = 0;
    #1;
    while ((u_master.got.size() < n || rpl.valid) && k < 300) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    // Realign to a rising edge so that the next request is launched there.
    @(posedge clk_sys);
    chk("reply_len", 32'(u_master.got.size()), 32'(n));
    chk("reply_last", 32'(u_master.last_at), 32'(n - 1));
  endtask
  // One clockwise step of the shaft.
  task automatic step_cw;
    enc_step <= 1'b1;
    enc_cw <= 1'b1;
    @(posedge clk_sys);
    enc_step <= 1'b0;
  endtask
  // Request a reply and measure its length.
  task automatic ask(input tlg_kind_t k, input logic [31:0] w, input int n);
    u_master.got.delete();
    if (k == KIND_DIAG) begin
      u_master.send(KIND_DIAG, 1'b0, '{8'h00});
    end else begin
      u_master.dx(w);
    end
    get_reply(n);
  endtask
  // Hang guard, far beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    wrap_up;
  end
  initial begin
    arst_n = 1'b0;
    addr_switch = 7'h19;
    enc_step = 1'b0;
    enc_cw = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("node_addr", 32'(node_addr), 32'h19);
    get_reply(16);
    rd(REG_STATUS, d);
    st = status_t'(d);
    chk("mode", 32'(st.mode), 32'(MODE_PRM));
    // A parameter frame that stops before the operating byte is refused.
    u_master.send(KIND_PRM, 1'b0, '{8'h00, 8'h00, 8'h00});
    rd(REG_STATUS, d);
    st = status_t'(d);
    chk("prm_err", 32'(st.prm_err), 32'h1);
    chk("mode_short", 32'(st.mode), 32'(MODE_PRM));
    rd(REG_STORED_ADDR, d);
    chk("stored", d, 32'h7D);
    u_master.send(KIND_SETADR, 1'b0, '{8'h06});
    rd(REG_STORED_ADDR, d);
    chk("stored_c1", d, 32'h7D);
    u_master.send(KIND_SETADR, 1'b1, '{8'h06});
    rd(REG_STORED_ADDR, d);
    chk("stored_c2", d, 32'h06);
    chk("node_kept", 32'(node_addr), 32'h19);
    // Class 2 with velocity and long diagnostics.
    u_master.prm(8'hC2);
    u_master.send(KIND_CFG, 1'b0, '{8'h08});
    rd(REG_STATUS, d);
    st = status_t'(d);
    chk("op_byte", 32'(st.op_byte), 32'hC2);
    chk("prm_err_clr", 32'(st.prm_err), 32'h0);
    chk("mode_dx", 32'(st.mode), 32'(MODE_DXCH));
    u_master.slow = 1'b1;
    ask(KIND_DIAG, 32'h0, 63);
    u_master.slow = 1'b0;
    wr(REG_SPEED, 32'h000000AB);
    ask(KIND_DXCH, 32'h80000500, 8);
    chk("pos_out", {u_master.got[0], u_master.got[1], u_master.got[2], u_master.got[3]}, 32'h500);
    chk("spd_out", {u_master.got[4], u_master.got[5], u_master.got[6], u_master.got[7]}, 32'hAB);
    ask(KIND_DXCH, 32'h00001234, 8);
    chk("pos_idle", {u_master.got[0], u_master.got[1], u_master.got[2], u_master.got[3]}, 32'h500);
    rd(REG_POSITION, d);
    chk("pos_kept", d, 32'h500);
    step_cw();
    rd(REG_POSITION, d);
    chk("pos_cw", d, 32'h501);
    // Class 1, reverse direction; diagnostic bit set but class 1 stays short.
    u_master.prm(8'h41);
    u_master.send(KIND_CFG, 1'b0, '{8'h08});
    rd(REG_STATUS, d);
    st = status_t'(d);
    chk("cfg_err", 32'(st.cfg_err), 32'h1);
    chk("mode_cfg", 32'(st.mode), 32'(MODE_CFG));
    u_master.send(KIND_CFG, 1'b0, '{8'h04});
    rd(REG_CFG_LEN, d);
    chk("cfg_len", d, 32'h4);
    step_cw();
    rd(REG_POSITION, d);
    chk("pos_ccw", d, 32'h500);
    ask(KIND_DXCH, 32'h0, 4);
    ask(KIND_DIAG, 32'h0, 16);
    // A diagnostic request during a data reply is kept and answered after it.
    u_master.got.delete();
    u_master.dx(32'h0);
    u_master.send(KIND_DIAG, 1'b0, '{8'h00});
    get_reply(20);
    rd(REG_STATUS, d);
    st = status_t'(d);
    chk("overrun", 32'(st.overrun), 32'h1);
    rd(REG_STATUS, d);
    st = status_t'(d);
    chk("overrun_clr", 32'(st.overrun), 32'h0);
    // Power-up again with the reserved switch code.
    arst_n <= 1'b0;
    addr_switch <= 7'h7E;
    repeat (2) @(posedge clk_sys);
    u_master.got.delete();
    arst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("node_stored", 32'(node_addr), 32'h7D);
    get_reply(16);
    rd(REG_STATUS, d);
    st = status_t'(d);
    chk("from_store", 32'(st.from_store), 32'h1);
    wrap_up;
  end
endmodule
`default_nettype wire
